/* File: rtl/ucl_pkg.sv */
// package of constants, types and helpers for the usb configuration low bits block
package ucl_pkg;
    // ****************************************************************
    // register map and field positions
    // ****************************************************************
    localparam logic [11:0] ADDR_CFG = 12'h000; // configuration low bits
    localparam logic [11:0] ADDR_CTRL = 12'h004; // lite reset and protection
    localparam logic [11:0] ADDR_STAT = 12'h008; // block state
    localparam int B_SBP = 0; // bulk_out_stall_disable
    localparam int B_PWR = 1; // power_method_select
    localparam int B_RWK = 2; // remote_wakeup_support
    localparam int B_SWAP = 4; // line swap, read only
    localparam int B_BLE = 5; // burst_limit_enable
    localparam int B_SLEEP = 8; // phy_sleep_l1_enable
    localparam int B_U2X = 11; // u2 exit lfps select
    localparam int B_MULTI = 13; // three-bit field, bits 15:13
    localparam int B_LITE_RESET = 0; // ctrl: lite_reset, self clearing
    localparam int B_PROT = 1; // ctrl: reset protection
    // flag byte positions inside the configuration image
    localparam int F0_SWAP = 0; // nv_line_swap_flag
    localparam int F0_PWR = 1; // nv_power_method_flag
    localparam int F0_RWK = 2; // remote wakeup flag
    localparam int F1_SLEEP = 0; // phy sleep flag
    localparam int F1_MULTI = 1; // multi field, bits 3:1
    localparam int F2_U2X = 0; // u2 exit flag
    // fixed defaults when no storage provides a value
    localparam logic FIX_SWAP = 1'b0;
    localparam logic FIX_RWK = 1'b1;
    localparam logic FIX_PWR = 1'b1;
    localparam logic FIX_SLEEP = 1'b1;
    localparam logic [2:0] FIX_MULTI = 3'h3;
    localparam logic FIX_U2X = 1'b0;
    localparam logic RST_BLE = 1'b0;
    localparam logic RST_SBP = 1'b0;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_NS = 10; // pclk period
    localparam int LFPS_SHORT_NS = 248;
    localparam int LFPS_LONG_US = 8;
    localparam logic [9:0] LFPS_SHORT_CYC = 10'((LFPS_SHORT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] LFPS_LONG_CYC = 10'((LFPS_LONG_US * 1000 + CLK_NS - 1) / CLK_NS);
    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic eeprom; // image came from eeprom
        logic otp; // image came from otp
        logic swap;
        logic pwr;
        logic rwk;
        logic sleep;
        logic [2:0] multi;
        logic u2x;
    } ucl_img_s;
    typedef struct packed {
        logic [2:0] multi;
        logic u2x;
        logic sleep;
        logic ble;
        logic swap;
        logic rwk;
        logic pwr;
        logic bulk_out_stall_disable;
    } ucl_cfg_s;
    // register word view of the configuration; bit 3 stays zero
    function automatic logic [31:0] cfg_word(input ucl_cfg_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[B_SBP] = c.bulk_out_stall_disable;
        w[B_PWR] = c.pwr;
        w[B_RWK] = c.rwk;
        w[B_SWAP] = c.swap;
        w[B_BLE] = c.ble;
        w[B_SLEEP] = c.sleep;
        w[B_U2X] = c.u2x;
        w[B_MULTI +: 3] = c.multi;
        return w;
    endfunction : cfg_word
endpackage : ucl_pkg

/* File: rtl/ucl_img_if.sv */
// carrier for the loaded configuration image
`timescale 1ns/1ns
`default_nettype none
interface ucl_img_if;
    ucl_pkg::ucl_img_s img; // last loaded image
    logic loaded; // one-cycle pulse: image just replaced
    modport src (output img, output loaded);
    modport dst (input img, input loaded);
endinterface : ucl_img_if
`default_nettype wire

/* File: rtl/ucl_nv_image.sv */
// holder of the default image taken from eeprom, otp or fixed values
`timescale 1ns/1ns
`default_nettype none
module ucl_nv_image (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic nv_load_valid, // pulse: bytes below are valid
    input wire logic nv_eeprom_present, // eeprom image present
    input wire logic nv_otp_programmed, // otp holds a programmed image
    input wire logic [7:0] nv_cfg0, // flag byte 0
    input wire logic [7:0] nv_cfg1, // flag byte 1
    input wire logic [7:0] nv_cfg2, // flag byte 2
    ucl_img_if.src img_o // image and load pulse
);
    typedef struct packed {
        ucl_pkg::ucl_img_s img;
        logic loaded;
    } ucl_nvi_s;
    ucl_nvi_s st_q; // all state
    ucl_nvi_s st_d; // next state
    logic src; // some storage supplies the bytes
    // ****************************************************************
    // image selection
    // ****************************************************************
    // eeprom first, otp second, fixed values last
    always_comb
    begin
        st_d = st_q;
        st_d.loaded = nv_load_valid;
        src = nv_eeprom_present | nv_otp_programmed;
        if (nv_load_valid)
        begin
            st_d.img.eeprom = nv_eeprom_present;
            st_d.img.otp = ~nv_eeprom_present & nv_otp_programmed;
            st_d.img.swap = src ? nv_cfg0[ucl_pkg::F0_SWAP] : ucl_pkg::FIX_SWAP;
            st_d.img.rwk = src ? nv_cfg0[ucl_pkg::F0_RWK] : ucl_pkg::FIX_RWK;
            // otp has no say on the power bit
            st_d.img.pwr = nv_eeprom_present ? nv_cfg0[ucl_pkg::F0_PWR] : ucl_pkg::FIX_PWR;
            st_d.img.sleep = src ? nv_cfg1[ucl_pkg::F1_SLEEP] : ucl_pkg::FIX_SLEEP;
            st_d.img.multi = src ? nv_cfg1[ucl_pkg::F1_MULTI +: 3] : ucl_pkg::FIX_MULTI;
            st_d.img.u2x = src ? nv_cfg2[ucl_pkg::F2_U2X] : ucl_pkg::FIX_U2X;
        end
    end
    // state register; reset holds the fixed image
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= '{img: '{eeprom: 1'b0, otp: 1'b0, swap: ucl_pkg::FIX_SWAP,
                pwr: ucl_pkg::FIX_PWR, rwk: ucl_pkg::FIX_RWK, sleep: ucl_pkg::FIX_SLEEP,
                multi: ucl_pkg::FIX_MULTI, u2x: ucl_pkg::FIX_U2X}, loaded: 1'b0};
        else
            st_q <= st_d;
    end
    assign img_o.img = st_q.img;
    assign img_o.loaded = st_q.loaded;
    // ****************************************************************
    // checks
    // ****************************************************************
    property p_fixed_fallback;
        @(posedge pclk) disable iff (!presetn)
        nv_load_valid && !nv_eeprom_present && !nv_otp_programmed |=>
            st_q.img.multi == 3'h3 && st_q.img.rwk && st_q.img.sleep && !st_q.img.u2x
            && !st_q.img.swap;
    endproperty
    a_fixed_fallback: assert property (p_fixed_fallback)
        else $error("fixed defaults not applied");
    property p_otp_no_power;
        @(posedge pclk) disable iff (!presetn)
        nv_load_valid && !nv_eeprom_present && nv_otp_programmed |=>
            st_q.img.pwr && st_q.img.swap == $past(nv_cfg0[0]);
    endproperty
    a_otp_no_power: assert property (p_otp_no_power)
        else $error("otp image handled wrongly");
endmodule : ucl_nv_image
`default_nettype wire

/* File: rtl/ucl_pin_map.sv */
// registered high-speed pin mapping with optional line swap
`timescale 1ns/1ns
`default_nettype none
module ucl_pin_map (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic swap, // exchange the two pins
    input wire logic tx_dp, // line driver d+
    input wire logic tx_dm, // line driver d-
    input wire logic tx_oe, // line driver enable
    output logic pos_o, // hs_positive_pin value
    output logic neg_o, // hs_negative_pin value
    output logic oe_o // enable for both pins
);
    typedef struct packed {
        logic pos;
        logic neg;
        logic oe;
    } ucl_pin_s;
    ucl_pin_s st_q; // all state
    ucl_pin_s st_d; // next state
    // mux before the flop so the pins never glitch on a swap change
    always_comb
    begin
        st_d.oe = tx_oe;
        st_d.pos = swap ? tx_dm : tx_dp;
        st_d.neg = swap ? tx_dp : tx_dm;
    end
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end
    assign pos_o = st_q.pos;
    assign neg_o = st_q.neg;
    assign oe_o = st_q.oe;
endmodule : ucl_pin_map
`default_nettype wire

/* File: rtl/ucl_top.sv */
// top of the usb configuration low bits block with its apb register slave
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ucl_top (
    input wire logic pclk, // clock, 100 mhz
    input wire logic presetn, // async reset, active low
    input wire logic [11:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic nv_load_valid, // pulse: configuration bytes valid
    input wire logic nv_eeprom_present, // eeprom present
    input wire logic nv_otp_programmed, // otp programmed
    input wire logic [7:0] nv_cfg0, // flag byte 0
    input wire logic [7:0] nv_cfg1, // flag byte 1
    input wire logic [7:0] nv_cfg2, // flag byte 2
    input wire logic usb_reset, // pulse: usb bus reset seen
    input wire logic loss_of_sync, // pulse: rx fifo lost sync
    input wire logic stall_clear, // pulse: host clears the stall
    input wire logic set_dev_rwk, // pulse: host enables device wakeup
    input wire logic set_fn_rwk, // pulse: host enables function wakeup
    input wire logic clr_dev_rwk, // pulse: host disables device wakeup
    input wire logic clr_fn_rwk, // pulse: host disables function wakeup
    input wire logic [7:0] burst_cap_value, // burst capacity register value
    input wire logic tx_dp, // line driver d+
    input wire logic tx_dm, // line driver d-
    input wire logic tx_oe, // line driver enable
    output logic hs_positive_pin_o, // positive pin drive
    output logic hs_negative_pin_o, // negative pin drive
    output logic hs_pin_oe, // pin output enable
    output logic tx_burst_cap_en, // burst cap in force
    output logic [7:0] tx_burst_cap, // burst cap, zero when off
    output logic self_powered, // reported power mode
    output logic dev_rwk_en, // device remote wakeup enabled
    output logic fn_rwk_en, // function remote wakeup enabled
    output logic bulk_out_stall, // bulk-out pipe stalled
    output logic phy_sleep_l1_enable, // phy sleep and l1 suspend
    output logic [9:0] u2_exit_lfps_cycles, // lfps length for u2 exit
    output logic [2:0] cfg_multi // three-bit configuration field
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        ucl_pkg::ucl_cfg_s cfg; // configuration low bits
        logic protect; // reset protection
        logic dev_rwk; // device wakeup enabled
        logic fn_rwk; // function wakeup enabled
        logic stall; // bulk-out stalled
        logic pready; // apb ready
        logic pslverr; // apb error
        logic [31:0] prdata; // apb read data
        logic cap_en; // burst cap enable out
        logic [7:0] cap; // burst cap out
        logic [9:0] lfps; // lfps cycles out
    } ucl_top_s;
    ucl_top_s st_q; // all state
    ucl_top_s st_d; // next state
    logic wr; // write takes effect this edge
    logic lite; // lite reset request this cycle
    logic rst_any; // usb or lite reset this cycle
    logic [31:0] stat_w; // status word
    ucl_img_if img (); // image carrier
    // ****************************************************************
    // submodules
    // ****************************************************************
    // default image holder
    ucl_nv_image u_img (
        .pclk(pclk),
        .presetn(presetn),
        .nv_load_valid(nv_load_valid),
        .nv_eeprom_present(nv_eeprom_present),
        .nv_otp_programmed(nv_otp_programmed),
        .nv_cfg0(nv_cfg0),
        .nv_cfg1(nv_cfg1),
        .nv_cfg2(nv_cfg2),
        .img_o(img.src)
    );
    // pin mapping follows the swap bit
    ucl_pin_map u_pin (
        .pclk(pclk),
        .presetn(presetn),
        .swap(st_q.cfg.swap),
        .tx_dp(tx_dp),
        .tx_dm(tx_dm),
        .tx_oe(tx_oe),
        .pos_o(hs_positive_pin_o),
        .neg_o(hs_negative_pin_o),
        .oe_o(hs_pin_oe)
    );
    // ****************************************************************
    // next state
    // ****************************************************************
    // apb answers with zero wait: ready is raised from the setup cycle
    always_comb
    begin
        st_d = st_q;
        stat_w = 32'h0000_0000;
        stat_w[0] = st_q.dev_rwk;
        stat_w[1] = st_q.fn_rwk;
        stat_w[2] = st_q.stall;
        stat_w[3] = img.img.eeprom;
        stat_w[4] = img.img.otp;
        // setup cycle: decode and fetch read data
        st_d.pready = psel & ~penable;
        st_d.pslverr = 1'b0;
        st_d.prdata = 32'h0000_0000;
        if (psel && !penable)
        begin
            unique case (paddr)
                ucl_pkg::ADDR_CFG: st_d.prdata = ucl_pkg::cfg_word(st_q.cfg);
                ucl_pkg::ADDR_CTRL: st_d.prdata[ucl_pkg::B_PROT] = st_q.protect;
                ucl_pkg::ADDR_STAT: st_d.prdata = stat_w;
                default: st_d.pslverr = 1'b1; // unmapped: error, no effect
            endcase
        end
        wr = psel & penable & st_q.pready & pwrite & ~st_q.pslverr;
        lite = 1'b0;
        // software writes; swap and bit 3 ignore them
        if (wr && paddr == ucl_pkg::ADDR_CFG)
        begin
            st_d.cfg.bulk_out_stall_disable = pwdata[ucl_pkg::B_SBP];
            st_d.cfg.pwr = pwdata[ucl_pkg::B_PWR];
            st_d.cfg.rwk = pwdata[ucl_pkg::B_RWK];
            st_d.cfg.ble = pwdata[ucl_pkg::B_BLE];
            st_d.cfg.sleep = pwdata[ucl_pkg::B_SLEEP];
            st_d.cfg.u2x = pwdata[ucl_pkg::B_U2X];
            st_d.cfg.multi = pwdata[ucl_pkg::B_MULTI +: 3];
        end
        if (wr && paddr == ucl_pkg::ADDR_CTRL)
        begin
            st_d.protect = pwdata[ucl_pkg::B_PROT];
            lite = pwdata[ucl_pkg::B_LITE_RESET]; // self clearing, never stored
        end
        rst_any = usb_reset | lite;
        // a fresh image loads all six image fields, protected or not; ble and bulk_out_stall_disable keep their values
        if (img.loaded)
        begin
            st_d.cfg.swap = img.img.swap;
            st_d.cfg.rwk = img.img.rwk;
            st_d.cfg.pwr = img.img.pwr;
            st_d.cfg.sleep = img.img.sleep;
            st_d.cfg.multi = img.img.multi;
            st_d.cfg.u2x = img.img.u2x;
        end
        else if (rst_any)
        begin
            // restore from the last image; protection keeps two bits
            st_d.cfg.swap = img.img.swap;
            st_d.cfg.sleep = img.img.sleep;
            st_d.cfg.multi = img.img.multi;
            st_d.cfg.u2x = img.img.u2x;
            if (!st_q.protect)
            begin
                st_d.cfg.rwk = img.img.rwk;
                st_d.cfg.pwr = img.img.pwr;
            end
        end
        // wakeup features: set wins over clear, gated by support bit
        st_d.dev_rwk = ((st_q.dev_rwk & ~clr_dev_rwk & ~rst_any) | set_dev_rwk)
            & st_d.cfg.rwk;
        st_d.fn_rwk = ((st_q.fn_rwk & ~clr_fn_rwk & ~rst_any) | set_fn_rwk)
            & st_d.cfg.rwk;
        // loss of sync stalls unless disabled; a new stall beats a clear
        st_d.stall = (st_q.stall & ~stall_clear & ~usb_reset)
            | (loss_of_sync & ~st_q.cfg.bulk_out_stall_disable);
        // burst cap of zero means no limit downstream
        st_d.cap_en = st_q.cfg.ble;
        st_d.cap = st_q.cfg.ble ? burst_cap_value : 8'h00;
        // short filter trades glitch immunity for faster u2 exit
        st_d.lfps = st_q.cfg.u2x ? ucl_pkg::LFPS_SHORT_CYC : ucl_pkg::LFPS_LONG_CYC;
    end
    // state register; reset takes fixed defaults until an image loads
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q <= '0;
            st_q.cfg.swap <= ucl_pkg::FIX_SWAP;
            st_q.cfg.rwk <= ucl_pkg::FIX_RWK;
            st_q.cfg.pwr <= ucl_pkg::FIX_PWR;
            st_q.cfg.sleep <= ucl_pkg::FIX_SLEEP;
            st_q.cfg.multi <= ucl_pkg::FIX_MULTI;
            st_q.cfg.u2x <= ucl_pkg::FIX_U2X;
            st_q.cfg.ble <= ucl_pkg::RST_BLE;
            st_q.cfg.bulk_out_stall_disable <= ucl_pkg::RST_SBP;
            st_q.lfps <= ucl_pkg::LFPS_LONG_CYC;
        end
        else
            st_q <= st_d;
    end
    // ****************************************************************
    // outputs
    // ****************************************************************
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign tx_burst_cap_en = st_q.cap_en;
    assign tx_burst_cap = st_q.cap;
    assign self_powered = st_q.cfg.pwr;
    assign dev_rwk_en = st_q.dev_rwk;
    assign fn_rwk_en = st_q.fn_rwk;
    assign bulk_out_stall = st_q.stall;
    assign phy_sleep_l1_enable = st_q.cfg.sleep;
    assign u2_exit_lfps_cycles = st_q.lfps;
    assign cfg_multi = st_q.cfg.multi;
    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_cap_off;
        !st_q.cfg.ble |=> !tx_burst_cap_en && tx_burst_cap == 8'h00;
    endproperty
    a_cap_off: assert property (p_cap_off)
        else $error("burst cap active while disabled");
    property p_cap_on;
        st_q.cfg.ble |=> tx_burst_cap == $past(burst_cap_value);
    endproperty
    a_cap_on: assert property (p_cap_on)
        else $error("burst cap not taken from capacity value");
    property p_swap;
        st_q.cfg.swap && $stable(st_q.cfg.swap) |=>
            hs_positive_pin_o == $past(tx_dm) && hs_negative_pin_o == $past(tx_dp);
    endproperty
    a_swap: assert property (p_swap)
        else $error("pins not exchanged under swap");
    property p_rwk_gate;
        !st_q.cfg.rwk |-> !dev_rwk_en && !fn_rwk_en;
    endproperty
    a_rwk_gate: assert property (p_rwk_gate)
        else $error("wakeup enabled without support");
    property p_stall;
        loss_of_sync && !st_q.cfg.bulk_out_stall_disable |=> bulk_out_stall;
    endproperty
    a_stall: assert property (p_stall)
        else $error("bulk-out not stalled on loss of sync");
    property p_no_stall;
        loss_of_sync && st_q.cfg.bulk_out_stall_disable && !bulk_out_stall |=> !bulk_out_stall;
    endproperty
    a_no_stall: assert property (p_no_stall)
        else $error("bulk-out stalled while disabled");
    property p_restore;
        usb_reset && !img.loaded && !st_q.protect && !wr |=>
            self_powered == $past(img.img.pwr) && cfg_multi == $past(img.img.multi);
    endproperty
    a_restore: assert property (p_restore)
        else $error("usb reset did not restore image");
    property p_protect;
        usb_reset && !img.loaded && st_q.protect && !wr |=>
            $stable(self_powered) && $stable(st_q.cfg.rwk);
    endproperty
    a_protect: assert property (p_protect)
        else $error("protected bits changed on reset");
    property p_lfps;
        st_q.cfg.u2x ##1 st_q.cfg.u2x |-> u2_exit_lfps_cycles == ucl_pkg::LFPS_SHORT_CYC;
    endproperty
    a_lfps: assert property (p_lfps)
        else $error("wrong short lfps count");
    property p_rsvd;
        // only the configuration word has a reserved bit 3; status uses it
        pready && paddr == ucl_pkg::ADDR_CFG |-> !prdata[3];
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit reads one");
endmodule : ucl_top
`default_nettype wire

/* File: bench/ucl_nv_model.sv */
// behavioural model of the nonvolatile configuration storage
`timescale 1ns/1ns
`default_nettype none
module ucl_nv_model (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic go, // bench asks for one image load
    input wire logic [25:0] src, // eeprom flag, otp flag, bytes 2..0
    output logic nv_load_valid, // one-cycle load pulse
    output logic [25:0] nv_bus // present flags and flag bytes
);
    // ****************************************************************
    // load sequencer
    // ****************************************************************
    // between loads the bus shows the inverse of its last value, so a
    // design that samples outside the pulse sees garbage, not a copy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nv_load_valid <= 1'b0;
            nv_bus <= 26'h0;
        end
        else
        begin
            nv_load_valid <= go;
            nv_bus <= go ? src : ~nv_bus;
        end
    end
endmodule : ucl_nv_model
`default_nettype wire

/* File: bench/tb_usb_config_low_bits.sv */
// self-checking bench for the usb configuration low bits block
`timescale 1ns/1ns
`default_nettype none
module tb_usb_config_low_bits;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, nv_load_valid, self_powered, dev_rwk_en, fn_rwk_en, stall, err;
    logic usb_reset = 0, loss_of_sync = 0, stall_clear = 0, set_dev = 0, set_fn = 0;
    logic clr_dev = 0, clr_fn = 0, pos, neg, oe, cap_en, sleep;
    logic [25:0] src = 26'h0, nv_bus;
    logic [7:0] cap;
    logic [9:0] u2c;
    logic [2:0] multi;
    int fails = 0, total_checks = 0;
    initial forever #5 pclk = ~pclk;
    ucl_nv_model ucl_nv_model_i (.pclk(pclk), .presetn(presetn), .go(go), .src(src),
        .nv_load_valid(nv_load_valid), .nv_bus(nv_bus));
    ucl_top ucl_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nv_load_valid(nv_load_valid),
        .nv_eeprom_present(nv_bus[25]), .nv_otp_programmed(nv_bus[24]),
        .nv_cfg0(nv_bus[7:0]), .nv_cfg1(nv_bus[15:8]), .nv_cfg2(nv_bus[23:16]),
        .usb_reset(usb_reset), .loss_of_sync(loss_of_sync), .stall_clear(stall_clear),
        .set_dev_rwk(set_dev), .set_fn_rwk(set_fn), .clr_dev_rwk(clr_dev),
        .clr_fn_rwk(clr_fn), .burst_cap_value(8'h5a), .tx_dp(1'b1), .tx_dm(1'b0),
        .tx_oe(1'b1), .hs_positive_pin_o(pos), .hs_negative_pin_o(neg), .hs_pin_oe(oe),
        .tx_burst_cap_en(cap_en), .tx_burst_cap(cap), .self_powered(self_powered),
        .dev_rwk_en(dev_rwk_en), .fn_rwk_en(fn_rwk_en), .bulk_out_stall(stall),
        .phy_sleep_l1_enable(sleep), .u2_exit_lfps_cycles(u2c), .cfg_multi(multi));
    // verdict and end of run, also reached by an expired wait
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) $display("Error %s expected %h seen %h", name, exp, seen);
        if (seen !== exp) fails++;
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // one apb transfer; waits on pready with a bounded count
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) fails++;
        if (n == 20) conclude();
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rdcfg(input logic [31:0] exp);
        apb(1'b0, ucl_pkg::ADDR_CFG, 32'h0);
        check("cfg", rd, exp);
    endtask : rdcfg
    // one-cycle pulse on an event input, then let outputs settle
    task automatic pulse(input int k);
        @(posedge pclk);
        case (k)
            0: usb_reset <= 1'b1;
            1: loss_of_sync <= 1'b1;
            2: stall_clear <= 1'b1;
            3: set_dev <= 1'b1;
            4: set_fn <= 1'b1;
            5: clr_dev <= 1'b1;
            default: clr_fn <= 1'b1;
        endcase
        @(posedge pclk);
        {usb_reset, loss_of_sync, stall_clear, set_dev, set_fn, clr_dev, clr_fn} <= 7'h00;
        tick(2);
    endtask : pulse
    task automatic load(input logic [25:0] v);
        @(posedge pclk);
        {go, src} <= {1'b1, v};
        @(posedge pclk);
        go <= 1'b0;
        tick(4);
    endtask : load
    // fixed defaults, writes to read-only bits, unmapped address
    task automatic t_defaults();
        rdcfg(32'h0000_6106);
        check("sleep", sleep, ucl_pkg::FIX_SLEEP);
        check("multi", multi, ucl_pkg::FIX_MULTI);
        check("u2 long", u2c, ucl_pkg::LFPS_LONG_CYC);
        apb(1'b1, ucl_pkg::ADDR_CFG, 32'hffff_ffff);
        rdcfg(32'h0000_e927);
        check("cap", {cap_en, cap}, 9'h15a);
        check("u2 short", u2c, ucl_pkg::LFPS_SHORT_CYC);
        apb(1'b0, 12'h0ff0, 32'h0);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0000_0000);
    endtask : t_defaults
    // eeprom image first, then otp only with power taken from eeprom alone
    task automatic t_images();
        load(26'h2_01_00_01);
        rdcfg(32'h0000_0831);
        check("pins", {pos, neg, oe}, 3'b011);
        apb(1'b0, ucl_pkg::ADDR_STAT, 32'h0);
        check("stat eeprom", rd, 32'h0000_0008);
        load(26'h1_00_0e_00);
        rdcfg(32'h0000_e023);
        check("pins", {pos, neg, oe}, 3'b101);
        apb(1'b1, ucl_pkg::ADDR_CFG, 32'h0);
        pulse(0);
        rdcfg(32'h0000_e002);
        apb(1'b1, ucl_pkg::ADDR_CFG, 32'h0);
        apb(1'b1, ucl_pkg::ADDR_CTRL, 32'h1);
        rdcfg(32'h0000_e002);
        apb(1'b1, ucl_pkg::ADDR_CTRL, 32'h2);
        apb(1'b0, ucl_pkg::ADDR_CTRL, 32'h0);
        check("protect", rd, 32'h0000_0002);
        apb(1'b1, ucl_pkg::ADDR_CFG, 32'h4);
        pulse(0);
        rdcfg(32'h0000_e004);
        check("bus powered", self_powered, 1'b0);
        apb(1'b1, ucl_pkg::ADDR_CTRL, 32'h0);
        // no storage: bytes of all ones must be ignored in favour of fixed values
        load(26'h0_ff_ff_ff);
        rdcfg(32'h0000_6106);
    endtask : t_images
    // wakeup enables gated by support, stall on loss of sync
    task automatic t_events();
        pulse(3);
        check("dev wake", dev_rwk_en, 1'b1);
        pulse(5);
        check("dev wake clr", dev_rwk_en, 1'b0);
        pulse(4);
        check("fn wake on", fn_rwk_en, 1'b1);
        pulse(6);
        check("fn wake clr", fn_rwk_en, 1'b0);
        pulse(3);
        apb(1'b1, ucl_pkg::ADDR_CFG, 32'h0);
        tick(1);
        check("dev wake off", dev_rwk_en, 1'b0);
        pulse(4);
        check("fn wake", fn_rwk_en, 1'b0);
        pulse(1);
        check("stall", stall, 1'b1);
        apb(1'b0, ucl_pkg::ADDR_STAT, 32'h0);
        check("stat stall", rd, 32'h0000_0004);
        pulse(2);
        check("stall clr", stall, 1'b0);
        apb(1'b1, ucl_pkg::ADDR_CFG, 32'h1);
        pulse(1);
        check("no stall", stall, 1'b0);
    endtask : t_events
    initial
    begin
        tick(8);
        presetn <= 1'b1;
        t_defaults();
        t_images();
        t_events();
        conclude();
    end
endmodule : tb_usb_config_low_bits
`default_nettype wire
